// file: rtl/achs_pkg.sv
`default_nettype none
package achs_pkg;
  localparam int NUM_IN   = 256;
  localparam int NUM_OUT  = 56;
  localparam int IN_SEL_W = 8;
  localparam int HEAD_W   = 6;
  localparam int CODE_W   = 7;
  localparam int MULT_W   = 8;
  localparam int EXP_W    = 3;

  localparam logic [CODE_W-1:0] CODE_MAX = 7'h63;

  // Single-axis and dual-axis point allocation for the auxiliary code.
  localparam int S_STROBE_PT = 0;
  localparam int S_UNITS_PT  = 1;
  localparam int S_TENS_PT   = 5;
  localparam int DIGIT_W     = 4;
  localparam int DUAL_SPAN   = 8;

  localparam logic [HEAD_W-1:0] D_HEAD_MAX = 6'h2F;

  // Input numbers allowed for the clear command.
  localparam logic [IN_SEL_W-1:0] S_CLR_LO_MAX = 8'h03;
  localparam logic [IN_SEL_W-1:0] S_CLR_HI_MIN = 8'hFD;
  localparam logic [IN_SEL_W-1:0] D_CLR_LO_MAX = 8'h37;
  localparam logic [IN_SEL_W-1:0] D_CLR_HI_MIN = 8'hFA;

  // Handwheel phase inputs and enable input ranges.
  localparam int HW_XA_PT = 0;
  localparam int HW_XB_PT = 1;
  localparam int HW_YA_PT = 2;
  localparam int HW_YB_PT = 3;
  localparam logic [IN_SEL_W-1:0] HW_EN_MIN    = 8'h02;
  localparam logic [IN_SEL_W-1:0] HW_EN_MIN_2  = 8'h04;
  localparam logic [IN_SEL_W-1:0] S_HW_EN_MAX  = 8'h03;
  localparam logic [IN_SEL_W-1:0] D_HW_EN_MAX  = 8'h37;

  localparam logic [1:0] HW_OFF = 2'h0;
  localparam logic [1:0] HW_ONE = 2'h1;
  localparam logic [1:0] HW_TWO = 2'h2;

  typedef enum logic {
    ACHS_IDLE,
    ACHS_STROBE
  } achs_state_t;
endpackage : achs_pkg
`default_nettype wire

// file: rtl/achs_scaler.sv
`default_nettype none
module achs_scaler #(
  parameter int MULT_W = 8,
  parameter int EXP_W  = 3,
  parameter int ACC_W  = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              phase_a,
  input  wire logic              phase_b,
  input  wire logic              accept,
  input  wire logic [MULT_W-1:0] multiplier,
  input  wire logic [EXP_W-1:0]  exponent,
  output logic                   pulse,
  output logic                   dir
);
  logic                    a_reg, a_next;
  logic signed [ACC_W-1:0] acc_reg, acc_next;
  logic                    pulse_reg, pulse_next;
  logic                    dir_reg, dir_next;
  logic signed [ACC_W-1:0] step;
  logic signed [ACC_W-1:0] thr;
  logic [MULT_W-1:0]       mult_eff;

  always_comb begin
    mult_eff = (multiplier == '0) ? MULT_W'(1) : multiplier;
    thr      = ACC_W'(1) <<< exponent;
    step     = '0;
    if (accept && phase_a && !a_reg) begin
      // Phase B low on the A rising edge means forward rotation.
      step = phase_b ? -$signed(ACC_W'(mult_eff))
                     : $signed(ACC_W'(mult_eff));
    end
    a_next     = phase_a;
    acc_next   = acc_reg + step;
    pulse_next = 1'b0;
    dir_next   = dir_reg;
    // The remainder below the threshold stays in the accumulator.
    if (acc_reg >= thr) begin
      pulse_next = 1'b1;
      dir_next   = 1'b0;
      acc_next   = acc_reg + step - thr;
    end else if (acc_reg <= -thr) begin
      pulse_next = 1'b1;
      dir_next   = 1'b1;
      acc_next   = acc_reg + step + thr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      a_reg     <= 1'b0;
      acc_reg   <= '0;
      pulse_reg <= 1'b0;
      dir_reg   <= 1'b0;
    end else begin
      a_reg     <= a_next;
      acc_reg   <= acc_next;
      pulse_reg <= pulse_next;
      dir_reg   <= dir_next;
    end
  end

  assign pulse = pulse_reg;
  assign dir   = dir_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_PULSE_NEEDS_CREDIT: assert property (
    pulse |-> ($past(acc_reg) >= $past(thr)) || ($past(acc_reg) <= -$past(thr)))
    else $error("Output pulse without accumulated credit.");
  AST_NO_STEP_WITHOUT_ACCEPT: assert property (
    !accept && acc_reg == '0 |=> acc_reg == '0)
    else $error("Accumulator moved while pulses were not accepted.");
  AST_REMAINDER_KEPT: assert property (
    !accept && !pulse_next |=> acc_reg == $past(acc_reg))
    else $error("Remainder lost between input pulses.");
  COV_PULSE: cover property (pulse && !dir);
endmodule : achs_scaler
`default_nettype wire

// file: rtl/achs_top.sv
`default_nettype none
module achs_top #(
  parameter bit DUAL_AXIS = 1'b1,
  parameter int ACC_W     = 12
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic [achs_pkg::NUM_IN-1:0]   in_points,
  input  wire logic                          aux_code_output_enable,
  input  wire logic [achs_pkg::HEAD_W-1:0]   aux_code_output_head_point,
  input  wire logic [achs_pkg::IN_SEL_W-1:0] aux_code_clear_input_select,
  input  wire logic [1:0]                    handwheel_enable_select,
  input  wire logic [achs_pkg::IN_SEL_W-1:0] handwheel_enable_input_select,
  input  wire logic [achs_pkg::MULT_W-1:0]   handwheel_multiplier_x,
  input  wire logic [achs_pkg::MULT_W-1:0]   handwheel_multiplier_y,
  input  wire logic [achs_pkg::EXP_W-1:0]    handwheel_divider_exponent_x,
  input  wire logic [achs_pkg::EXP_W-1:0]    handwheel_divider_exponent_y,
  input  wire logic                          aux_code_exec,
  input  wire logic [achs_pkg::CODE_W-1:0]   aux_code_in,
  output logic                               aux_code_ready,
  output logic                               aux_code_active,
  output logic [achs_pkg::CODE_W-1:0]        aux_code_value,
  output logic                               aux_code_cleared,
  output logic [achs_pkg::NUM_OUT-1:0]       aux_out,
  output logic [1:0]                         hw_pulse,
  output logic [1:0]                         hw_dir
);
  localparam int NO = achs_pkg::NUM_OUT;
  localparam int DW = achs_pkg::DIGIT_W;

  function automatic logic [2*DW-1:0] to_bcd(
      input logic [achs_pkg::CODE_W-1:0] code);
    logic [achs_pkg::CODE_W-1:0] tens;
    logic [achs_pkg::CODE_W-1:0] units;
    tens  = code / achs_pkg::CODE_W'(10);
    units = code - tens * achs_pkg::CODE_W'(10);
    return {tens[DW-1:0], units[DW-1:0]};
  endfunction : to_bcd

  function automatic logic in_range(
      input logic [achs_pkg::IN_SEL_W-1:0] v,
      input logic [achs_pkg::IN_SEL_W-1:0] lo,
      input logic [achs_pkg::IN_SEL_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  achs_pkg::achs_state_t          state_reg, state_next;
  logic [achs_pkg::CODE_W-1:0]    code_reg, code_next;
  logic                           cleared_reg, cleared_next;
  logic [NO-1:0]                  out_reg, out_next;
  logic                           clr_sel_ok, clr_hit, exec_ok;
  logic [2*DW-1:0]                bcd;
  logic                           head_ok, strobe_next;
  logic [achs_pkg::HEAD_W-1:0]    head_eff;

  always_comb begin
    if (DUAL_AXIS) begin
      clr_sel_ok = (aux_code_clear_input_select <= achs_pkg::D_CLR_LO_MAX)
                || (aux_code_clear_input_select >= achs_pkg::D_CLR_HI_MIN);
    end else begin
      clr_sel_ok = (aux_code_clear_input_select <= achs_pkg::S_CLR_LO_MAX)
                || (aux_code_clear_input_select >= achs_pkg::S_CLR_HI_MIN);
    end
  end

  assign clr_hit = clr_sel_ok && in_points[aux_code_clear_input_select];
  assign exec_ok = aux_code_exec && (state_reg == achs_pkg::ACHS_IDLE)
                && (aux_code_in <= achs_pkg::CODE_MAX);

  // The code, active flag and clear flag run regardless of output enable.
  always_comb begin
    state_next   = state_reg;
    code_next    = code_reg;
    cleared_next = 1'b0;
    case (state_reg)
      achs_pkg::ACHS_IDLE: begin
        if (exec_ok) begin
          code_next  = aux_code_in;
          state_next = achs_pkg::ACHS_STROBE;
        end
      end
      achs_pkg::ACHS_STROBE: begin
        if (clr_hit) begin
          state_next   = achs_pkg::ACHS_IDLE;
          cleared_next = 1'b1;
        end
      end
      default: state_next = achs_pkg::ACHS_IDLE;
    endcase
  end

  // Point image is built from the next state so it lines up with the flag.
  always_comb begin
    bcd         = to_bcd(code_next);
    strobe_next = (state_next == achs_pkg::ACHS_STROBE);
    head_ok     = aux_code_output_head_point <= achs_pkg::D_HEAD_MAX;
    head_eff    = aux_code_output_head_point;
    out_next    = '0;
    if (aux_code_output_enable) begin
      if (!DUAL_AXIS) begin
        out_next[achs_pkg::S_STROBE_PT]       = strobe_next;
        out_next[achs_pkg::S_UNITS_PT +: DW]  = bcd[DW-1:0];
        out_next[achs_pkg::S_TENS_PT]         = bcd[DW];
      end else if (head_ok) begin
        out_next[head_eff]                    = strobe_next;
        out_next[head_eff + 1 +: achs_pkg::DUAL_SPAN] = bcd;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg   <= achs_pkg::ACHS_IDLE;
      code_reg    <= '0;
      cleared_reg <= 1'b0;
      out_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      code_reg    <= code_next;
      cleared_reg <= cleared_next;
      out_reg     <= out_next;
    end
  end

  assign aux_code_ready   = (state_reg == achs_pkg::ACHS_IDLE);
  assign aux_code_active  = (state_reg == achs_pkg::ACHS_STROBE);
  assign aux_code_value   = code_reg;
  assign aux_code_cleared = cleared_reg;
  assign aux_out          = out_reg;

  // Handwheel section; one-wheel and two-wheel enable settings, two-wheel only with DUAL_AXIS.
  logic [1:0] hw_mode;
  logic       en_sel_ok, en_x, en_y, y_side;
  logic [1:0] accept;
  logic [1:0] ph_a, ph_b;
  logic [achs_pkg::IN_SEL_W-1:0] sel_nx;

  always_comb begin
    hw_mode = handwheel_enable_select;
    if (!DUAL_AXIS && hw_mode != achs_pkg::HW_ONE) begin
      hw_mode = achs_pkg::HW_OFF;
    end
    sel_nx = handwheel_enable_input_select + achs_pkg::IN_SEL_W'(1);
    if (!DUAL_AXIS) begin
      en_sel_ok = in_range(handwheel_enable_input_select,
                           achs_pkg::HW_EN_MIN, achs_pkg::S_HW_EN_MAX);
    end else if (hw_mode == achs_pkg::HW_TWO) begin
      en_sel_ok = in_range(handwheel_enable_input_select,
                           achs_pkg::HW_EN_MIN_2, achs_pkg::D_HW_EN_MAX);
    end else begin
      en_sel_ok = in_range(handwheel_enable_input_select,
                           achs_pkg::HW_EN_MIN, achs_pkg::D_HW_EN_MAX);
    end
    en_x   = en_sel_ok && in_points[handwheel_enable_input_select];
    en_y   = en_sel_ok && in_points[sel_nx];
    y_side = DUAL_AXIS && en_y;
    accept = 2'b00;
    ph_a   = {in_points[achs_pkg::HW_YA_PT], in_points[achs_pkg::HW_XA_PT]};
    ph_b   = {in_points[achs_pkg::HW_YB_PT], in_points[achs_pkg::HW_XB_PT]};
    case (hw_mode)
      achs_pkg::HW_ONE: begin
        // One wheel on inputs 0 and 1, steered to Y by the next input when DUAL_AXIS is set.
        accept = y_side ? {en_x, 1'b0} : {1'b0, en_x};
        ph_a   = {2{in_points[achs_pkg::HW_XA_PT]}};
        ph_b   = {2{in_points[achs_pkg::HW_XB_PT]}};
      end
      achs_pkg::HW_TWO: accept = {en_y, en_x};
      default:          accept = 2'b00;
    endcase
  end

  logic [achs_pkg::MULT_W-1:0] mult_ax [2];
  logic [achs_pkg::EXP_W-1:0]  exp_ax  [2];
  assign mult_ax[0] = handwheel_multiplier_x;
  assign mult_ax[1] = handwheel_multiplier_y;
  assign exp_ax[0]  = DUAL_AXIS ? handwheel_divider_exponent_x : '0;
  assign exp_ax[1]  = DUAL_AXIS ? handwheel_divider_exponent_y : '0;

  for (genvar g = 0; g < 2; g++) begin : g_axis
    achs_scaler #(
      .MULT_W (achs_pkg::MULT_W),
      .EXP_W  (achs_pkg::EXP_W),
      .ACC_W  (ACC_W)
    ) u_scaler (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .phase_a    (ph_a[g]),
      .phase_b    (ph_b[g]),
      .accept     (accept[g]),
      .multiplier (mult_ax[g]),
      .exponent   (exp_ax[g]),
      .pulse      (hw_pulse[g]),
      .dir        (hw_dir[g])
    );
  end

  // Digits of the held code, for the point checks below.
  logic [2*DW-1:0] bcd_now;
  assign bcd_now = to_bcd(code_reg);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_OUT_DISABLED: assert property (
    !aux_code_output_enable |=> aux_out == '0)
    else $error("Points driven while external output disabled.");
  AST_INTERNAL_WHEN_OFF: assert property (
    !aux_code_output_enable && exec_ok |=> aux_code_active
      && aux_code_value == $past(aux_code_in))
    else $error("Internal code not kept while output disabled.");
  AST_SINGLE_MAP: assert property (
    !DUAL_AXIS && $past(aux_code_output_enable) && aux_code_active |->
      aux_out[achs_pkg::S_STROBE_PT]
      && aux_out[achs_pkg::S_UNITS_PT +: DW] == bcd_now[DW-1:0])
    else $error("Single-axis strobe or units digit wrong.");
  AST_TENS_ODD: assert property (
    !DUAL_AXIS && $past(aux_code_output_enable) |->
      aux_out[achs_pkg::S_TENS_PT] == bcd_now[DW])
    else $error("Tens odd point does not follow the code.");
  AST_DUAL_MAP: assert property (
    DUAL_AXIS && $past(aux_code_output_enable) && aux_code_active
      && $past(head_ok) |->
      aux_out[$past(head_eff)]
      && aux_out[$past(head_eff) + 1 +: achs_pkg::DUAL_SPAN]
         == to_bcd(code_reg))
    else $error("Dual-axis strobe or digits wrong.");
  AST_EXEC_STROBE: assert property (
    exec_ok |=> aux_code_active ##1 aux_code_active || $past(clr_hit))
    else $error("Strobe not raised by code execution.");
  AST_HOLD_UNTIL_CLEAR: assert property (
    aux_code_active && !clr_hit |=> aux_code_active && !aux_code_cleared)
    else $error("Strobe dropped without clear command.");
  AST_CLEAR_DROPS: assert property (
    aux_code_active && clr_hit |=> !aux_code_active && aux_code_cleared
      ##1 !aux_code_cleared)
    else $error("Clear command did not end the strobe.");
  AST_BAD_CLEAR_SEL: assert property (
    aux_code_active && !clr_sel_ok |=> aux_code_active)
    else $error("Clear taken from a disallowed input.");
  AST_NO_ACCEPT_OFF: assert property (
    hw_mode == achs_pkg::HW_OFF |-> accept == 2'b00)
    else $error("Handwheel accepted while disabled.");

  COV_STROBE: cover property (exec_ok ##1 aux_code_active);
  COV_CLEAR: cover property (aux_code_active ##1 aux_code_cleared);
  COV_HW_X: cover property (hw_pulse[0]);
  COV_HW_Y: cover property (hw_pulse[1]);
endmodule : achs_top
`default_nettype wire

// file: testbench/achs_plc_model.sv
`default_nettype none
module achs_plc_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [55:0] aux_out,
  input  wire logic [5:0]  head,
  input  wire logic [7:0]  lag,
  output logic             clear_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_cnt;

  // The equipment runs for lag cycles, then the clear line stays up until
  // the strobe drops. A released input point reads as off.
  always @(posedge sys_clk) begin
    if (!reset_n || !aux_out[head]) begin
      clear_cmd <= 1'b0;
      wait_cnt  <= 8'h00;
    end else if (wait_cnt == lag) begin
      clear_cmd <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule : achs_plc_model
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SELS [4] = '{8'h00, 8'h37, 8'hFA, 8'hFF};
  logic         sys_clk, reset_n, en, exec, clr, ready, active, cleared;
  logic         was_active;
  logic [255:0] pts, in_points;
  logic [55:0]  aux_out;
  logic [55:0]  exp_q[$];
  logic [7:0]   clr_sel, hw_sel, mx, my, lag;
  logic [6:0]   code, value;
  logic [5:0]   head;
  logic [2:0]   nx, ny;
  logic [1:0]   hw_mode, hw_pulse, hw_dir;
  int           err_total, n_tests, cyc, cnt_x, cnt_y;
  logic         clr_s, active_s, was_s;
  logic [255:0] in_points_s;
  logic [55:0]  aux_out_s;
  logic [55:0]  exp_s[$];
  logic [7:0]   clr_sel_s;
  logic [1:0]   hw_pulse_s;
  int           cnt_s;

  assign in_points = pts | (256'(clr) << clr_sel);
  assign in_points_s = pts | (256'(clr_s) << clr_sel_s);

  achs_top #(.DUAL_AXIS(1'b1), .ACC_W(12)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .in_points(in_points),
    .aux_code_output_enable(en), .aux_code_output_head_point(head),
    .aux_code_clear_input_select(clr_sel),
    .handwheel_enable_select(hw_mode),
    .handwheel_enable_input_select(hw_sel),
    .handwheel_multiplier_x(mx), .handwheel_multiplier_y(my),
    .handwheel_divider_exponent_x(nx), .handwheel_divider_exponent_y(ny),
    .aux_code_exec(exec), .aux_code_in(code), .aux_code_ready(ready),
    .aux_code_active(active), .aux_code_value(value),
    .aux_code_cleared(cleared), .aux_out(aux_out),
    .hw_pulse(hw_pulse), .hw_dir(hw_dir));

  achs_plc_model u_plc (.sys_clk(sys_clk), .reset_n(reset_n),
    .aux_out(aux_out), .head(head), .lag(lag), .clear_cmd(clr));

  // Single-axis variant, driven by the same stimulus but with its own clear input select and PLC model.
  achs_top #(.DUAL_AXIS(1'b0), .ACC_W(12)) u_dut_s (
    .sys_clk(sys_clk), .reset_n(reset_n), .in_points(in_points_s),
    .aux_code_output_enable(en), .aux_code_output_head_point(head),
    .aux_code_clear_input_select(clr_sel_s),
    .handwheel_enable_select(hw_mode),
    .handwheel_enable_input_select(hw_sel),
    .handwheel_multiplier_x(mx), .handwheel_multiplier_y(my),
    .handwheel_divider_exponent_x(nx), .handwheel_divider_exponent_y(ny),
    .aux_code_exec(exec), .aux_code_in(code), .aux_code_ready(),
    .aux_code_active(active_s), .aux_code_value(),
    .aux_code_cleared(), .aux_out(aux_out_s),
    .hw_pulse(hw_pulse_s), .hw_dir());

  achs_plc_model u_plc_s (.sys_clk(sys_clk), .reset_n(reset_n),
    .aux_out(aux_out_s), .head(6'h00), .lag(lag), .clear_cmd(clr_s));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(string what, logic [63:0] e, logic [63:0] s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check

  function automatic logic [55:0] pattern(logic [6:0] c, logic [5:0] h);
    logic [8:0] f;
    f = {4'(c / 10), 4'(c % 10), 1'b1};
    return 56'(f) << h;
  endfunction : pattern

  function automatic logic [55:0] pattern_s(logic [6:0] c);
    logic [5:0] f;
    f = {1'(c / 10), 4'(c % 10), 1'b1};
    return 56'(f);
  endfunction : pattern_s

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!reset_n) begin
      cnt_x <= 0;
      cnt_y <= 0;
    end else begin
      cnt_x <= cnt_x + hw_pulse[0];
      cnt_y <= cnt_y + hw_pulse[1];
      cnt_s <= cnt_s + hw_pulse_s[0] + hw_pulse_s[1];
    end
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end

  // Takes the oldest note each time a code becomes active.
  always @(negedge sys_clk) begin
    if (active === 1'b1 && was_active !== 1'b1) begin
      if (exp_q.size() == 0) check("queue", 1, 0);
      else check("aux_out", exp_q.pop_front(), aux_out);
    end
    if (active_s === 1'b1 && was_s !== 1'b1) begin
      if (exp_s.size() == 0) check("queue_s", 1, 0);
      else check("aux_out_s", exp_s.pop_front(), aux_out_s);
    end
    was_active = active;
    was_s = active_s;
  end

  task automatic issue(logic [6:0] c, logic [5:0] h, logic e);
    @(posedge sys_clk);
    head <= h;
    en   <= e;
    @(posedge sys_clk);
    code <= c;
    exec <= 1'b1;
    exp_q.push_back(e ? pattern(c, h) : 56'h0);
    exp_s.push_back(e ? pattern_s(c) : 56'h0);
    @(posedge sys_clk);
    code <= c ^ 7'h01;
    @(posedge sys_clk);
    exec <= 1'b0;
    if (!e) pts[clr_sel] <= 1'b1;
  endtask : issue

  task automatic await_clear(logic [6:0] c, logic [5:0] h, logic e);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (cleared !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    check("cleared", 1'b1, cleared);
    check("value", c, value);
    check("ready", 1'b1, ready);
    check("aux_end", e ? pattern(c, h) & ~(56'h1 << h) : 56'h0, aux_out);
    @(posedge sys_clk);
    if (!e) pts[clr_sel] <= 1'b0;
    $display("test code %0d done", c);
  endtask : await_clear

  task automatic hw_case(logic [1:0] md, logic [7:0] sel, logic [1:0] lv,
                         int ap, logic b, int n, int ex, int ey);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    hw_mode <= md;
    hw_sel  <= sel;
    pts     <= '0;
    @(posedge sys_clk);
    reset_n      <= 1'b1;
    pts[sel]     <= lv[0];
    pts[sel + 1] <= lv[1];
    pts[ap + 1]  <= b;
    repeat (n) begin
      @(posedge sys_clk);
      pts[ap] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pts[ap] <= 1'b0;
      repeat (300) @(posedge sys_clk);
    end
    @(negedge sys_clk);
    check("pulses_x", ex, cnt_x);
    check("pulses_y", ey, cnt_y);
    check("hw_dir", {b & (ey > 0), b & (ex > 0)}, hw_dir);
    $display("test wheel mode %0d done", md);
  endtask : hw_case

  initial begin
    logic [6:0] c;
    logic [5:0] h;
    int         rm;
    int         rn;
    reset_n = 1'b0;
    en = 1'b1;
    exec = 1'b0;
    pts = '0;
    clr_sel = 8'h07;
    hw_sel = 8'h0A;
    mx = 8'h03;
    my = 8'h05;
    nx = 3'h1;
    ny = 3'h2;
    lag = 8'h02;
    code = 7'h00;
    head = 6'h00;
    hw_mode = 2'h0;
    clr_sel_s = 8'hFF;
    void'($urandom(43));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("ready", 1'b1, ready);
    check("reset_out", 56'h0, aux_out);
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 7'h00 : (i == 1) ? 7'h63 : 7'($urandom % 100);
      h = (i == 0) ? 6'h00 : (i == 1) ? 6'h2F : 6'($urandom % 48);
      @(posedge sys_clk);
      clr_sel <= SELS[i % 4];
      clr_sel_s <= (i % 2) ? 8'hFF : 8'hFD;
      lag     <= 8'($urandom % 20 + 1);
      issue(c, h, 1'b1);
      await_clear(c, h, 1'b1);
    end
    @(posedge sys_clk);
    code <= 7'h64;
    exec <= 1'b1;
    @(posedge sys_clk);
    exec <= 1'b0;
    @(negedge sys_clk);
    check("refused", 1'b0, active);
    issue(7'h2A, 6'h05, 1'b0);
    await_clear(7'h2A, 6'h05, 1'b0);
    @(posedge sys_clk);
    clr_sel <= 8'h38;
    issue(7'h15, 6'h07, 1'b1);
    repeat (40) @(negedge sys_clk);
    check("held", 1'b1, active);
    @(posedge sys_clk);
    clr_sel <= 8'h07;
    await_clear(7'h15, 6'h07, 1'b1);
    hw_case(2'h1, 8'h0A, 2'b01, 0, 1'b0, 5, 7, 0);
    hw_case(2'h1, 8'h0A, 2'b11, 0, 1'b1, 3, 0, 3);
    @(posedge sys_clk);
    my <= 8'hFF;
    ny <= 3'h7;
    hw_case(2'h2, 8'h04, 2'b11, 2, 1'b0, 4, 0, 7);
    hw_case(2'h1, 8'h0A, 2'b00, 0, 1'b0, 3, 0, 0);
    hw_case(2'h0, 8'h0A, 2'b01, 0, 1'b0, 3, 0, 0);
    rm = $urandom % 255 + 1;
    rn = $urandom % 8;
    @(posedge sys_clk);
    mx <= 8'(rm);
    nx <= 3'(rn);
    hw_case(2'h1, 8'h0A, 2'b01, 0, 1'b1, 6, (6 * rm) >> rn, 0);
    check("queue_left", 0, exp_q.size() + exp_s.size());
    check("pulses_s", 0, cnt_s);
    complete_run();
  end
endmodule : tb
`default_nettype wire
